/* File: rtl/critical_conduction_gate_sequencer.sv */
// Switching sequencer of a critical conduction power factor controller.
`timescale 1ns/100ps
`include "gate_seq_cfg.svh"

// Behaviour
// - Start only once supply lockout reports the start threshold reached.
// - Supply falling to stop level forces gate low and returns to idle.
// - On-width grows softly, following the rising compensation compare.
// - Gate off for the restart interval triggers an own on pulse.
// - Normally zero current detect, not the restart timer, ends off time.
// - Every on period ends by the max on interval at the latest.
// - Zero current while off turns the gate on after the turn-on wait.
// - The turn-on wait is a configurable duration.
// - Gate stays off at least the min off interval each cycle.
// - If min off outlasts freewheeling, wait it out, then proceed.
// - Overvoltage drives the gate low at once and halts switching.
// - Resume after overvoltage only once the comparator releases.
// - On time ends when the ramp reaches the compensation level.
// - Switching self-starts and alternates on and off continuously.
module critical_conduction_gate_sequencer
    import gate_seq_pkg::*;
#(
    parameter logic [`GS_CNT_W-1:0] MAX_ON_CYC = `GS_CNT_W'(`GS_MAX_ON_CYC),
    parameter logic [`GS_CNT_W-1:0] TURN_ON_WAIT_CYC = `GS_CNT_W'(`GS_TURN_ON_WAIT_CYC),
    parameter logic [`GS_CNT_W-1:0] RESTART_CYC = `GS_CNT_W'(`GS_RESTART_CYC),
    parameter logic [`GS_CNT_W-1:0] MIN_OFF_CYC = `GS_CNT_W'(`GS_MIN_OFF_CYC)
) (
    input wire logic SYS_CLK_IN,
    input wire logic SRST_IN,
    input wire logic SUPPLY_LOCKOUT_OK_IN,
    input wire logic ZERO_CURRENT_DETECT_IN,
    input wire logic OVERVOLTAGE_GUARD_IN,
    input wire logic RAMP_REACHED_IN,
    output logic GATE_OUT,
    output logic RUNNING_OUT,
    output logic OVERVOLTAGE_HALT_OUT
);

    // ------------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------------
    cmp_t raw;
    cmp_t cmp;

    assign raw = '{supply_ok: SUPPLY_LOCKOUT_OK_IN,
                   zero_current: ZERO_CURRENT_DETECT_IN,
                   overvoltage: OVERVOLTAGE_GUARD_IN,
                   ramp_reached: RAMP_REACHED_IN};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            cmp_sync u_sync (
                .clk_in(SYS_CLK_IN),
                .rst_in(SRST_IN),
                .d_in(raw[gi]),
                .q_out(cmp[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------------------
    seq_state_t state_r;
    seq_state_t state_nxt;
    logic gate_r;
    logic gate_nxt;
    logic gate_fall;
    logic off_clear;
    logic phase_clear;
    logic [`GS_CNT_W-1:0] off_cnt;
    logic [`GS_CNT_W-1:0] phase_cnt;

    // restart off timers on gate fall
    assign gate_fall = gate_r && !gate_nxt;
    // Off timer also holds at zero while idle or halted, so the restart
    // interval is measured from the moment switching is permitted.
    assign off_clear = gate_fall || gate_r || state_r == ST_IDLE || state_r == ST_OVP;
    // Phase timer times the on period and the turn-on wait.
    assign phase_clear = state_nxt != state_r;

    interval_timer u_off_timer (
        .clk_in(SYS_CLK_IN),
        .rst_in(SRST_IN),
        .clear_in(off_clear),
        .count_out(off_cnt)
    );

    interval_timer u_phase_timer (
        .clk_in(SYS_CLK_IN),
        .rst_in(SRST_IN),
        .clear_in(phase_clear),
        .count_out(phase_cnt)
    );

    // ------------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------------
    logic min_off_done;
    logic restart_due;
    logic on_end;

    assign min_off_done = off_cnt >= MIN_OFF_CYC - `GS_CNT_W'(1);
    assign restart_due = off_cnt >= RESTART_CYC - `GS_CNT_W'(1);
    // ramp compare or max on ends the pulse
    assign on_end = cmp.ramp_reached || phase_cnt >= MAX_ON_CYC - `GS_CNT_W'(1);

    always_comb begin
        state_nxt = state_r;
        gate_nxt = 1'b0;
        if (!cmp.supply_ok) begin
            state_nxt = ST_IDLE;
        end else if (cmp.overvoltage && state_r != ST_IDLE) begin
            state_nxt = ST_OVP;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    state_nxt = ST_OFF;
                end
                // off period ends on zero current or restart
                ST_OFF: begin
                    if (min_off_done && restart_due) begin
                        state_nxt = ST_ON;
                        gate_nxt = 1'b1;
                    end else if (min_off_done && cmp.zero_current) begin
                        state_nxt = ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (phase_cnt >= TURN_ON_WAIT_CYC - `GS_CNT_W'(1)) begin
                        state_nxt = ST_ON;
                        gate_nxt = 1'b1;
                    end
                end
                // on width follows the compensation compare
                ST_ON: begin
                    if (on_end) begin
                        state_nxt = ST_OFF;
                    end else begin
                        gate_nxt = 1'b1;
                    end
                end
                ST_OVP: begin
                    state_nxt = ST_OFF;
                end
                default: begin
                    state_nxt = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            state_r <= ST_IDLE;
            gate_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            gate_r <= gate_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    // Gate comes straight from a flip-flop so no comparator glitch reaches the driver.
    assign GATE_OUT = gate_r;
    assign RUNNING_OUT = state_r != ST_IDLE;
    assign OVERVOLTAGE_HALT_OUT = state_r == ST_OVP;

endmodule : critical_conduction_gate_sequencer

/* File: rtl/gate_seq_cfg.svh */
// Timing and reset constants of the gate sequencer.
`ifndef GATE_SEQ_CFG_SVH
`define GATE_SEQ_CFG_SVH

// ----------------------------------------------------------------------------
// Clock
// ----------------------------------------------------------------------------
`define GS_CLK_MHZ 40
`define GS_CNT_W 16

// ----------------------------------------------------------------------------
// Times in ns and derived cycle counts
// ----------------------------------------------------------------------------
`define GS_RESTART_NS 50000
`define GS_RESTART_CYC ((`GS_RESTART_NS * `GS_CLK_MHZ) / 1000)
`define GS_MIN_OFF_NS 2500
`define GS_MIN_OFF_CYC ((`GS_MIN_OFF_NS * `GS_CLK_MHZ + 999) / 1000)
`define GS_MAX_ON_NS 23000
`define GS_MAX_ON_CYC ((`GS_MAX_ON_NS * `GS_CLK_MHZ) / 1000)
`define GS_TURN_ON_WAIT_NS 1350
`define GS_TURN_ON_WAIT_CYC ((`GS_TURN_ON_WAIT_NS * `GS_CLK_MHZ + 999) / 1000)

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define GS_SYNC_RST 1'b0

`endif

/* File: rtl/gate_seq_pkg.sv */
// Types shared by the gate sequencer modules.
package gate_seq_pkg;

    // ------------------------------------------------------------------------
    // Comparator decisions and sequencer states
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic supply_ok;
        logic zero_current;
        logic overvoltage;
        logic ramp_reached;
    } cmp_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_OFF,
        ST_WAIT,
        ST_ON,
        ST_OVP
    } seq_state_t;

endpackage : gate_seq_pkg

/* File: rtl/cmp_sync.sv */
// Two-stage synchroniser for one comparator bit.
`timescale 1ns/100ps
`include "gate_seq_cfg.svh"

module cmp_sync (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic d_in,
    output logic q_out
);

    logic meta_r;
    logic meta_nxt;
    logic q_r;
    logic q_nxt;

    always_comb begin
        meta_nxt = d_in;
        q_nxt = meta_r;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta_r <= `GS_SYNC_RST;
            q_r <= `GS_SYNC_RST;
        end else begin
            meta_r <= meta_nxt;
            q_r <= q_nxt;
        end
    end

    assign q_out = q_r;

endmodule : cmp_sync

/* File: rtl/interval_timer.sv */
// Up counter that restarts on demand and saturates.
`timescale 1ns/100ps
`include "gate_seq_cfg.svh"

module interval_timer (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic clear_in,
    output logic [`GS_CNT_W-1:0] count_out
);

    logic [`GS_CNT_W-1:0] cnt_r;
    logic [`GS_CNT_W-1:0] cnt_nxt;

    // Saturation keeps a long idle from wrapping and retriggering early.
    always_comb begin
        if (clear_in) begin
            cnt_nxt = '0;
        end else if (cnt_r != {`GS_CNT_W{1'b1}}) begin
            cnt_nxt = cnt_r + `GS_CNT_W'(1);
        end else begin
            cnt_nxt = cnt_r;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign count_out = cnt_r;

endmodule : interval_timer

/* File: dv/gate_seq_checker.sv */
// Port assertions for the gate sequencer.
`timescale 1ns/100ps
`include "gate_seq_cfg.svh"
module gate_seq_checker #(
    parameter logic [`GS_CNT_W-1:0] MAX_ON_CYC = `GS_CNT_W'(`GS_MAX_ON_CYC),
    parameter logic [`GS_CNT_W-1:0] TURN_ON_WAIT_CYC = `GS_CNT_W'(`GS_TURN_ON_WAIT_CYC),
    parameter logic [`GS_CNT_W-1:0] RESTART_CYC = `GS_CNT_W'(`GS_RESTART_CYC),
    parameter logic [`GS_CNT_W-1:0] MIN_OFF_CYC = `GS_CNT_W'(`GS_MIN_OFF_CYC)
) (
    input wire logic SYS_CLK_IN,
    input wire logic SRST_IN,
    input wire logic SUPPLY_LOCKOUT_OK_IN,
    input wire logic ZERO_CURRENT_DETECT_IN,
    input wire logic OVERVOLTAGE_GUARD_IN,
    input wire logic RAMP_REACHED_IN,
    input wire logic GATE_OUT,
    input wire logic RUNNING_OUT,
    input wire logic OVERVOLTAGE_HALT_OUT
);
    // Off time only counts while running, as the restart timer is held in idle and halt.
    logic [`GS_CNT_W-1:0] on_r;
    logic [`GS_CNT_W-1:0] off_r;
    always_ff @(posedge SYS_CLK_IN) begin
        on_r <= (SRST_IN || !GATE_OUT) ? '0 : on_r + 1'b1;
        off_r <= (SRST_IN || GATE_OUT || !RUNNING_OUT || OVERVOLTAGE_HALT_OUT) ? '0 : off_r + 1'b1;
    end
    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (SRST_IN);
    a_lockout_idle: assert property (
        !SUPPLY_LOCKOUT_OK_IN [*4] |-> !GATE_OUT && !RUNNING_OUT)
        else $error("gate active while supply is low");
    a_ov_gate_low: assert property (
        (SUPPLY_LOCKOUT_OK_IN && OVERVOLTAGE_GUARD_IN) [*4] |-> !GATE_OUT)
        else $error("gate high during overvoltage");
    a_ov_halt_set: assert property (
        (SUPPLY_LOCKOUT_OK_IN && OVERVOLTAGE_GUARD_IN) [*6] |-> OVERVOLTAGE_HALT_OUT)
        else $error("overvoltage halt not entered");
    a_ov_release: assert property (
        (SUPPLY_LOCKOUT_OK_IN && !OVERVOLTAGE_GUARD_IN) [*4] |-> !OVERVOLTAGE_HALT_OUT)
        else $error("overvoltage halt not released");
    a_stop_wins: assert property (OVERVOLTAGE_HALT_OUT |-> !GATE_OUT && RUNNING_OUT)
        else $error("gate on during halt");
    a_max_on: assert property (on_r <= MAX_ON_CYC)
        else $error("on period too long");
    a_min_off: assert property ($rose(GATE_OUT) |-> off_r >= MIN_OFF_CYC)
        else $error("off period too short");
    a_restart_due: assert property (off_r <= RESTART_CYC + TURN_ON_WAIT_CYC + 2'd2)
        else $error("restart pulse missing");
    // The ramp compare needs three edges to reach the gate, so by the fourth
    // sampled high cycle the gate must already be low.
    a_ramp_ends_on: assert property (RAMP_REACHED_IN [*4] |-> !GATE_OUT)
        else $error("on period outlived ramp compare");
    a_zc_turn_on: assert property (
        (ZERO_CURRENT_DETECT_IN && SUPPLY_LOCKOUT_OK_IN && !GATE_OUT && !OVERVOLTAGE_GUARD_IN
        && RUNNING_OUT && off_r >= MIN_OFF_CYC) [*3] |-> ##[0:10] GATE_OUT)
        else $error("no turn on after zero current");
endmodule : gate_seq_checker
bind critical_conduction_gate_sequencer gate_seq_checker #(.MAX_ON_CYC(MAX_ON_CYC),
    .TURN_ON_WAIT_CYC(TURN_ON_WAIT_CYC), .RESTART_CYC(RESTART_CYC), .MIN_OFF_CYC(MIN_OFF_CYC))
    i_checker (.SYS_CLK_IN(SYS_CLK_IN), .SRST_IN(SRST_IN),
    .SUPPLY_LOCKOUT_OK_IN(SUPPLY_LOCKOUT_OK_IN),
    .ZERO_CURRENT_DETECT_IN(ZERO_CURRENT_DETECT_IN), .OVERVOLTAGE_GUARD_IN(OVERVOLTAGE_GUARD_IN),
    .RAMP_REACHED_IN(RAMP_REACHED_IN), .GATE_OUT(GATE_OUT), .RUNNING_OUT(RUNNING_OUT),
    .OVERVOLTAGE_HALT_OUT(OVERVOLTAGE_HALT_OUT));

/* File: dv/gate_plant_model.sv */
// Behavioural plant: inductor current and ramp comparators around the gate.
`timescale 1ns/100ps
module gate_plant_model (
    input wire logic clk_in,
    input wire logic gate_in,
    input wire logic [15:0] on_lim_in,
    input wire logic [15:0] zc_after_in,
    output logic ramp_out,
    output logic zc_out
);
    logic [15:0] on_r = 16'h0000;
    logic [15:0] off_r = 16'h0000;
    initial begin
        ramp_out = 1'b0;
        zc_out = 1'b0;
    end
    always @(posedge clk_in) begin
        // An unknown gate before the first reset edge counts as off, so the
        // freewheel counter does not stay unknown until the first pulse.
        on_r <= (gate_in === 1'b1) ? on_r + 16'h0001 : 16'h0000;
        off_r <= (gate_in === 1'b1) ? 16'h0000 : off_r + 16'h0001;
        // ramp meets compensation after the set on width.
        ramp_out <= (gate_in === 1'b1) && (on_r + 16'h0001 >= on_lim_in);
        // current reaches zero once freewheeling ends.
        zc_out <= (gate_in !== 1'b1) && (off_r + 16'h0001 >= zc_after_in);
    end
endmodule : gate_plant_model

/* File: dv/critical_conduction_gate_sequencer_bench.sv */
// Self-checking bench of the gate sequencer.
`timescale 1ns/100ps
module critical_conduction_gate_sequencer_bench;
    localparam logic [15:0] MAX_ON = 16'h0028;
    logic clk = 1'b0, rst = 1'b1, sup = 1'b0, ov = 1'b0, ramp, zc, gate, run, halt;
    logic [15:0] lim = 16'h0001, zaf = 16'hffff, wid = 16'h0000;
    logic [31:0] lfsr = 32'h0000_19d5;
    logic [15:0] expq[$];
    int miscompares = 0, num_checks = 0;
    always #12.5 clk = ~clk;
    critical_conduction_gate_sequencer #(.MAX_ON_CYC(MAX_ON), .TURN_ON_WAIT_CYC(16'h0004),
        .RESTART_CYC(16'h00c8), .MIN_OFF_CYC(16'h000a)) i_dut (.SYS_CLK_IN(clk), .SRST_IN(rst),
        .SUPPLY_LOCKOUT_OK_IN(sup), .ZERO_CURRENT_DETECT_IN(zc), .OVERVOLTAGE_GUARD_IN(ov),
        .RAMP_REACHED_IN(ramp), .GATE_OUT(gate), .RUNNING_OUT(run), .OVERVOLTAGE_HALT_OUT(halt));
    gate_plant_model i_plant (.clk_in(clk), .gate_in(gate), .on_lim_in(lim), .zc_after_in(zaf),
        .ramp_out(ramp), .zc_out(zc));
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results
    // Each pulse is three cycles longer than the ramp delay, as the compare is synchronised, but never longer than MAX_ON.
    task automatic pulses(input string name, input logic [15:0] k, input logic [15:0] z,
        input int n);
        int t;
        @(posedge clk);
        lim <= k;
        zaf <= z;
        repeat (n) expq.push_back((k + 16'h0003 > MAX_ON) ? MAX_ON : k + 16'h0003);
        t = 0;
        while (expq.size() > 0 && t < 400 * n) begin
            @(posedge clk);
            t++;
        end
        if (expq.size() > 0) begin
            miscompares++;
            $display("mismatch %s pulses expected %0d seen %0d", name, n, n - expq.size());
            expq.delete();
        end
        $display("test %s done", name);
    endtask : pulses
    always @(posedge clk) begin
        if (gate) begin
            wid <= wid + 16'h0001;
        end else begin
            if (wid != 16'h0000 && expq.size() > 0) begin
                check("on width", wid, expq.pop_front());
            end
            wid <= 16'h0000;
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        sup <= 1'b1;
        pulses("restart start", 16'h0005, 16'hffff, 2);
        for (int i = 1; i < 5; i++) begin
            pulses("soft start", 16'(4 * i - 2), 16'h0014, 1);
        end
        pulses("short freewheel", 16'h0008, 16'h0002, 2);
        pulses("max on", 16'h003c, 16'h0014, 2);
        for (int i = 0; i < 6; i++) begin
            lfsr = lfsr_next(lfsr);
            pulses("random", 16'(lfsr % 50 + 1), 16'(lfsr[20:16]) + 16'h0001, 1);
        end
        @(posedge clk);
        zaf <= 16'hffff;
        ov <= 1'b1;
        repeat (10) @(posedge clk);
        check("halt", {15'h0000, halt}, 16'h0001);
        check("gate", {15'h0000, gate}, 16'h0000);
        ov <= 1'b0;
        pulses("overvoltage", 16'h0007, 16'h0014, 1);
        @(posedge clk);
        zaf <= 16'hffff;
        sup <= 1'b0;
        repeat (6) @(posedge clk);
        check("running", {15'h0000, run}, 16'h0000);
        check("gate", {15'h0000, gate}, 16'h0000);
        sup <= 1'b1;
        pulses("supply drop", 16'h0004, 16'h0014, 1);
        results();
    end
    initial begin
        #(25 * 40000);
        miscompares++;
        results();
    end
endmodule : critical_conduction_gate_sequencer_bench
